// *** inc/plcd_defines.svh ***
// Purpose: constants for the pulse-width lube command decoder
// Assumes: 250 MHz clock, 10 ms internal time base
// Notes: times below are in milliseconds; the decoder turns them into ticks
//
// Overview of operation
// - 4.9-5.1 s pulse: one stroke, unit two
// - 7.9-8.1 s pulse: stroke on both units
// - 11.9-12.1 s pulse: fill command
// - fill runs 40 strokes per fitted unit
// - 13.9-14.1 s pulse: acknowledge overload, voltage errors
// - status low: only acknowledge is accepted
// - commands need status high over 3 s
// - falling edge starts run, status low throughout
// - motor run lasts 7 to 17 s
// - clean run end returns status high
// - fill: status high 0.5 s between strokes
// - command line ignored 3 s after run
// - fault during run reported instead of high
// - controller sees low over 3 s first
// - acknowledge end runs self-check, pass means ready
// - 1.9-2.1 s pulse: one stroke, unit one
// - out-of-window or over 15 s: no reaction
// - empty: 0.5 Hz square wave, else low
`ifndef PLCD_DEFINES_SVH
`define PLCD_DEFINES_SVH

`define PLCD_CLK_PERIOD_NS 4
`define PLCD_TICK_MS 10
`define PLCD_TICK_CYCLES ((`PLCD_TICK_MS * 1000000) / `PLCD_CLK_PERIOD_NS)
`define PLCD_MS2TICK(ms) ((ms) / `PLCD_TICK_MS)
`define PLCD_DEB_CYCLES 16

`define PLCD_ONE_MIN_MS 1900
`define PLCD_ONE_MAX_MS 2100
`define PLCD_TWO_MIN_MS 4900
`define PLCD_TWO_MAX_MS 5100
`define PLCD_BOTH_MIN_MS 7900
`define PLCD_BOTH_MAX_MS 8100
`define PLCD_FILL_MIN_MS 11900
`define PLCD_FILL_MAX_MS 12100
`define PLCD_ACK_MIN_MS 13900
`define PLCD_ACK_MAX_MS 14100
`define PLCD_OVER_MS 15000
`define PLCD_STEADY_MS 3000
`define PLCD_GAP_MS 500
`define PLCD_BLINK_HALF_MS 1000
`define PLCD_RUN_MIN_MS 7000
`define PLCD_RUN_MAX_MS 17000
`define PLCD_FILL_STROKES 40

`endif

// *** inc/plcd_pkg.sv ***
// Purpose: types for the pulse-width lube command decoder
// Assumes: used together with plcd_defines.svh
// Notes: none
package plcd_pkg;
    typedef enum logic [2:0] {
        plcd_st_ready, plcd_st_run, plcd_st_gap, plcd_st_empty, plcd_st_error
    } plcd_state_t;
    typedef enum logic [2:0] {
        plcd_cmd_none, plcd_cmd_one, plcd_cmd_two, plcd_cmd_both, plcd_cmd_fill, plcd_cmd_ack
    } plcd_cmd_t;
endpackage

// *** hw/plcd_decoder.sv ***
// Purpose: decode pulse-length commands, run pump strokes, drive status line
// Assumes: command line asynchronous to clk; motor driver reports stroke end
// Notes: counts above tick level are in 10 ms ticks
`timescale 1ns/1ns
`include "plcd_defines.svh"
module plcd_decoder #(
    parameter int TICK_CYCLES = `PLCD_TICK_CYCLES,
    parameter int DEB_CYCLES = `PLCD_DEB_CYCLES,
    parameter int FILL_STROKES = `PLCD_FILL_STROKES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // command line from the controller
    input wire logic cmd_line,
    // pump hardware
    input wire logic unit_two_fitted,
    input wire logic motor_done,
    input wire logic overload_fault,
    input wire logic supply_voltage_fault,
    input wire logic empty_level_fault,
    input wire logic cartridge_present,
    input wire logic self_check_ok,
    // outputs
    output logic status_out,
    output logic pump_unit_one,
    output logic pump_unit_two,
    output logic critical_fault
);
    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam int DW = $clog2(DEB_CYCLES + 1);
    localparam logic [11:0] T_ONE_LO = 12'(`PLCD_MS2TICK(`PLCD_ONE_MIN_MS));
    localparam logic [11:0] T_ONE_HI = 12'(`PLCD_MS2TICK(`PLCD_ONE_MAX_MS));
    localparam logic [11:0] T_TWO_LO = 12'(`PLCD_MS2TICK(`PLCD_TWO_MIN_MS));
    localparam logic [11:0] T_TWO_HI = 12'(`PLCD_MS2TICK(`PLCD_TWO_MAX_MS));
    localparam logic [11:0] T_BOTH_LO = 12'(`PLCD_MS2TICK(`PLCD_BOTH_MIN_MS));
    localparam logic [11:0] T_BOTH_HI = 12'(`PLCD_MS2TICK(`PLCD_BOTH_MAX_MS));
    localparam logic [11:0] T_FILL_LO = 12'(`PLCD_MS2TICK(`PLCD_FILL_MIN_MS));
    localparam logic [11:0] T_FILL_HI = 12'(`PLCD_MS2TICK(`PLCD_FILL_MAX_MS));
    localparam logic [11:0] T_ACK_LO = 12'(`PLCD_MS2TICK(`PLCD_ACK_MIN_MS));
    localparam logic [11:0] T_ACK_HI = 12'(`PLCD_MS2TICK(`PLCD_ACK_MAX_MS));
    localparam logic [11:0] T_OVER = 12'(`PLCD_MS2TICK(`PLCD_OVER_MS));
    localparam logic [11:0] T_STEADY = 12'(`PLCD_MS2TICK(`PLCD_STEADY_MS));
    localparam logic [11:0] T_GAP = 12'(`PLCD_MS2TICK(`PLCD_GAP_MS));
    localparam logic [11:0] T_BLINK = 12'(`PLCD_MS2TICK(`PLCD_BLINK_HALF_MS));
    localparam logic [11:0] T_RUN_LO = 12'(`PLCD_MS2TICK(`PLCD_RUN_MIN_MS));
    localparam logic [11:0] T_RUN_HI = 12'(`PLCD_MS2TICK(`PLCD_RUN_MAX_MS));
    localparam logic [7:0] N_FILL = 8'(FILL_STROKES);
    localparam logic [11:0] SAT = 12'hfff;

    plcd_pkg::plcd_state_t state_r, state_nxt;
    logic [PW-1:0] pre_r;
    logic sync1_r, sync2_r, deb_r, deb_d_r;
    logic [DW-1:0] deb_cnt_r;
    logic [11:0] len_r, hold_r, tmr_r;
    logic [7:0] left_r, left_nxt, two_r, two_nxt;
    logic fill_r, fill_nxt, crit_r, crit_nxt, blink_r;
    logic status_r, status_nxt, motor_one_r, motor_two_r;

    // time base
    wire tick = (pre_r == PW'(TICK_CYCLES - 1));
    always_ff @(posedge clk) begin
        if (reset || tick) pre_r <= '0;
        else pre_r <= pre_r + 1'b1;
    end

    // input synchroniser and debounce; filter reads only the second stage
    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= cmd_line;
            sync2_r <= sync1_r;
        end
    end
    wire deb_flip = (sync2_r != deb_r) && (deb_cnt_r == DW'(DEB_CYCLES - 1));
    always_ff @(posedge clk) begin
        if (reset) begin
            deb_r <= 1'b0;
            deb_d_r <= 1'b0;
            deb_cnt_r <= '0;
        end else begin
            deb_r <= deb_flip ? sync2_r : deb_r;
            deb_d_r <= deb_r;
            deb_cnt_r <= (sync2_r == deb_r || deb_flip) ? '0 : deb_cnt_r + 1'b1;
        end
    end
    wire rise = deb_r && !deb_d_r;
    wire fall = !deb_r && deb_d_r;

    // pulse length in ticks, saturating past the over-long limit
    always_ff @(posedge clk) begin
        if (reset || rise) len_r <= '0;
        else if (deb_r && tick && len_r <= T_OVER) len_r <= len_r + 1'b1;
    end

    // classification: anything outside the windows decodes to none
    wire in_one = len_r >= T_ONE_LO && len_r <= T_ONE_HI;
    wire in_two = len_r >= T_TWO_LO && len_r <= T_TWO_HI;
    wire in_both = len_r >= T_BOTH_LO && len_r <= T_BOTH_HI;
    wire in_fill = len_r >= T_FILL_LO && len_r <= T_FILL_HI;
    wire in_ack = len_r >= T_ACK_LO && len_r <= T_ACK_HI;
    plcd_pkg::plcd_cmd_t cmd;
    assign cmd = !fall ? plcd_pkg::plcd_cmd_none :
                 in_one ? plcd_pkg::plcd_cmd_one :
                 in_two ? plcd_pkg::plcd_cmd_two :
                 in_both ? plcd_pkg::plcd_cmd_both :
                 in_fill ? plcd_pkg::plcd_cmd_fill :
                 in_ack ? plcd_pkg::plcd_cmd_ack : plcd_pkg::plcd_cmd_none;

    // status steady time, restarted on every level change
    wire steady = hold_r > T_STEADY;
    wire ready_ok = status_r && steady;
    wire err_ok = !status_r && steady;
    wire hw_fault = overload_fault || supply_voltage_fault;
    wire last = (left_r == 8'h01);
    wire done_ok = motor_done && tmr_r >= T_RUN_LO;
    wire run_short = motor_done && tmr_r < T_RUN_LO;
    wire run_long = tmr_r >= T_RUN_HI;
    wire blink_hit = (state_r == plcd_pkg::plcd_st_empty) && tick && tmr_r == T_BLINK - 1'b1;

    always_comb begin
        state_nxt = state_r;
        left_nxt = left_r;
        two_nxt = two_r;
        fill_nxt = fill_r;
        crit_nxt = crit_r;
        case (state_r)
            plcd_pkg::plcd_st_ready: begin
                if (hw_fault) begin
                    state_nxt = plcd_pkg::plcd_st_error;
                end else if (ready_ok && cmd != plcd_pkg::plcd_cmd_none) begin
                    fill_nxt = 1'b0;
                    if (cmd == plcd_pkg::plcd_cmd_one) begin
                        left_nxt = 8'h01;
                        two_nxt = 8'h00;
                        state_nxt = plcd_pkg::plcd_st_run;
                    end else if (cmd == plcd_pkg::plcd_cmd_two && unit_two_fitted) begin
                        left_nxt = 8'h01;
                        two_nxt = 8'h01;
                        state_nxt = plcd_pkg::plcd_st_run;
                    end else if (cmd == plcd_pkg::plcd_cmd_both) begin
                        left_nxt = unit_two_fitted ? 8'h02 : 8'h01;
                        two_nxt = unit_two_fitted ? 8'h01 : 8'h00;
                        state_nxt = plcd_pkg::plcd_st_run;
                    end else if (cmd == plcd_pkg::plcd_cmd_fill) begin
                        left_nxt = unit_two_fitted ? 8'(N_FILL + N_FILL) : N_FILL;
                        two_nxt = unit_two_fitted ? N_FILL : 8'h00;
                        fill_nxt = 1'b1;
                        state_nxt = plcd_pkg::plcd_st_run;
                    end
                end
            end
            plcd_pkg::plcd_st_run: begin
                if (hw_fault) begin
                    left_nxt = 8'h00;
                    state_nxt = plcd_pkg::plcd_st_error;
                end else if (run_short || run_long) begin
                    crit_nxt = 1'b1;
                    left_nxt = 8'h00;
                    state_nxt = plcd_pkg::plcd_st_error;
                end else if (done_ok) begin
                    left_nxt = left_r - 1'b1;
                    if (empty_level_fault) state_nxt = plcd_pkg::plcd_st_empty;
                    else if (last) state_nxt = plcd_pkg::plcd_st_ready;
                    else if (fill_r) state_nxt = plcd_pkg::plcd_st_gap;
                    else state_nxt = plcd_pkg::plcd_st_run;
                end
            end
            plcd_pkg::plcd_st_gap: begin
                if (tick && tmr_r == T_GAP - 1'b1) state_nxt = plcd_pkg::plcd_st_run;
            end
            plcd_pkg::plcd_st_empty: begin
                // a fill cut short by an empty cartridge resumes after the swap
                if (!empty_level_fault && cartridge_present) begin
                    state_nxt = (left_r != 8'h00) ? plcd_pkg::plcd_st_run
                                                  : plcd_pkg::plcd_st_ready;
                end
            end
            default: begin
                if (err_ok && cmd == plcd_pkg::plcd_cmd_ack && self_check_ok && !hw_fault
                    && !crit_r) begin
                    state_nxt = plcd_pkg::plcd_st_ready;
                end
            end
        endcase
    end

    wire tmr_clr = (state_nxt != state_r) || blink_hit
                   || (state_r == plcd_pkg::plcd_st_run && done_ok);
    assign status_nxt = (state_nxt == plcd_pkg::plcd_st_ready)
                        || (state_nxt == plcd_pkg::plcd_st_gap)
                        || (state_nxt == plcd_pkg::plcd_st_empty && cartridge_present
                            && (blink_r ^ blink_hit));

    always_ff @(posedge clk) begin
        if (reset) begin
            state_r <= plcd_pkg::plcd_st_ready;
            left_r <= 8'h00;
            two_r <= 8'h00;
            fill_r <= 1'b0;
            crit_r <= 1'b0;
            blink_r <= 1'b0;
            status_r <= 1'b1;
            motor_one_r <= 1'b0;
            motor_two_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            left_r <= left_nxt;
            two_r <= two_nxt;
            fill_r <= fill_nxt;
            crit_r <= crit_nxt;
            blink_r <= (state_nxt != plcd_pkg::plcd_st_empty) ? 1'b0 : blink_r ^ blink_hit;
            status_r <= status_nxt;
            motor_one_r <= state_nxt == plcd_pkg::plcd_st_run && left_nxt > two_nxt;
            motor_two_r <= state_nxt == plcd_pkg::plcd_st_run && left_nxt <= two_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || tmr_clr) tmr_r <= '0;
        else if (tick && tmr_r != SAT) tmr_r <= tmr_r + 1'b1;
    end
    // steady timer restarts with each status edge, which also blanks gap
    always_ff @(posedge clk) begin
        if (reset || status_nxt != status_r) hold_r <= '0;
        else if (tick && hold_r != SAT) hold_r <= hold_r + 1'b1;
    end

    assign status_out = status_r;
    assign pump_unit_one = motor_one_r;
    assign pump_unit_two = motor_two_r;
    assign critical_fault = crit_r;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_start;
        state_r == plcd_pkg::plcd_st_ready && !hw_fault && ready_ok
        && cmd == plcd_pkg::plcd_cmd_one
        |=> state_r == plcd_pkg::plcd_st_run && !status_out && pump_unit_one;
    endproperty
    a_start: assert property (p_start) else $error("accepted command did not start run");
    property p_run_low;
        state_r == plcd_pkg::plcd_st_run |-> !status_out && (pump_unit_one ^ pump_unit_two);
    endproperty
    a_run_low: assert property (p_run_low) else $error("status high during motor run");
    property p_gate;
        $rose(state_r == plcd_pkg::plcd_st_run) && $past(state_r) == plcd_pkg::plcd_st_ready
        |-> $past(ready_ok);
    endproperty
    a_gate: assert property (p_gate) else $error("command accepted before steady ready");
    property p_err_ignore;
        state_r == plcd_pkg::plcd_st_error && cmd != plcd_pkg::plcd_cmd_ack
        |=> state_r == plcd_pkg::plcd_st_error && !status_out;
    endproperty
    a_err_ignore: assert property (p_err_ignore)
        else $error("error state left without ack");
    property p_two_absent;
        state_r == plcd_pkg::plcd_st_ready && cmd == plcd_pkg::plcd_cmd_two && !unit_two_fitted
        && !hw_fault |=> state_r == plcd_pkg::plcd_st_ready;
    endproperty
    a_two_absent: assert property (p_two_absent)
        else $error("unit two stroke without unit");
    property p_fill_load;
        state_r == plcd_pkg::plcd_st_ready && !hw_fault && ready_ok
        && cmd == plcd_pkg::plcd_cmd_fill
        |=> left_r == (unit_two_fitted ? 8'(N_FILL + N_FILL) : N_FILL) && fill_r;
    endproperty
    a_fill_load: assert property (p_fill_load) else $error("fill stroke count wrong");
    property p_done_high;
        state_r == plcd_pkg::plcd_st_run && done_ok && !hw_fault && last && !empty_level_fault
        |=> status_out ##1 status_out;
    endproperty
    a_done_high: assert property (p_done_high) else $error("status not high after run");
    property p_gap;
        $rose(state_r == plcd_pkg::plcd_st_gap) |-> status_out throughout
            (state_r == plcd_pkg::plcd_st_gap)[*8];
    endproperty
    a_gap: assert property (p_gap) else $error("status not high in fill gap");
    property p_fault;
        state_r == plcd_pkg::plcd_st_run && hw_fault |=> state_r == plcd_pkg::plcd_st_error
            ##1 !status_out;
    endproperty
    a_fault: assert property (p_fault) else $error("run fault not reported");
    property p_ack;
        state_r == plcd_pkg::plcd_st_error && err_ok && cmd == plcd_pkg::plcd_cmd_ack
        && self_check_ok && !hw_fault && !crit_r
        |=> status_out && state_r == plcd_pkg::plcd_st_ready;
    endproperty
    a_ack: assert property (p_ack) else $error("passing ack did not restore ready");
    property p_no_len;
        fall && len_r > T_ACK_HI |-> cmd == plcd_pkg::plcd_cmd_none;
    endproperty
    a_no_len: assert property (p_no_len) else $error("over-long pulse decoded");
    // a run outside its time limits is sticky and cannot be acknowledged
    property p_crit;
        state_r == plcd_pkg::plcd_st_run && !hw_fault && (run_short || run_long)
        |=> critical_fault && state_r == plcd_pkg::plcd_st_error && !status_out;
    endproperty
    a_crit: assert property (p_crit) else $error("bad run length not flagged");

    c_fill: cover property (state_r == plcd_pkg::plcd_st_gap ##1 state_r == plcd_pkg::plcd_st_run);
    c_ack: cover property (state_r == plcd_pkg::plcd_st_error
        ##1 state_r == plcd_pkg::plcd_st_ready);
    c_empty: cover property (state_r == plcd_pkg::plcd_st_empty && status_out);
    c_both: cover property (pump_unit_one ##[1:1000] pump_unit_two);
endmodule

// *** test/plcd_plc_model.sv ***
// Purpose: controller model that drives the command line from the status line
// Assumes: tick of TC clock cycles; one command in flight at a time
// Notes: post-fill wait scales with FILL_STROKES so that runs stay short
`timescale 1ns/1ns
module plcd_plc_model #(
    parameter int TC = 2,
    parameter int FILL_STROKES = 40
) (
    // clock
    input wire logic clk,
    // device side
    input wire logic status_out,
    input wire logic unit_two_fitted,
    // command line
    output logic cmd_line
);
    int hi_cnt = 0;
    int lo_cnt = 0;
    int gap_left = 0;
    initial cmd_line = 1'b0;
    always @(posedge clk) begin
        hi_cnt <= (status_out === 1'b1) ? hi_cnt + 1 : 0;
        lo_cnt <= (status_out === 1'b0) ? lo_cnt + 1 : 0;
        if (gap_left > 0) gap_left <= gap_left - 1;
    end
    // guard: ack wants a steady low line, every other command a steady high one
    task automatic send(input int len, input bit guard, output bit ok);
        bit want_lo;
        int i;
        want_lo = len > 1300 && len < 1500;
        ok = 1'b1;
        if (guard) begin
            for (i = 0; i < 40000; i++) begin
                if (gap_left == 0 && (want_lo ? lo_cnt : hi_cnt) > 310 * TC) break;
                @(negedge clk);
            end
            ok = i < 40000;
        end
        cmd_line = 1'b1;
        repeat (len * TC) @(negedge clk);
        cmd_line = 1'b0;
        if (len > 1100 && len < 1300)
            gap_left = 70600 * FILL_STROKES / 40 * (unit_two_fitted ? 2 : 1) * TC;
        else if (len > 700 && len < 900) gap_left = 4500 * TC;
        else if (len > 400 && len < 600) gap_left = 2500 * TC;
    endtask
endmodule

// *** test/plcd_decoder_tb.sv ***
// Purpose: self-checking bench for the pulse-width command decoder
// Assumes: 10 ms tick shortened to 2 cycles, fill shortened to 2 strokes
// Notes: motor responder ends each run after run_len ticks
`timescale 1ns/1ns
module plcd_decoder_tb;
    localparam int TC = 2;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cmd_line, status_out, pump_unit_one, pump_unit_two, critical_fault;
    logic unit_two_fitted = 1'b1;
    logic motor_done = 1'b0;
    logic overload_fault = 1'b0;
    logic supply_voltage_fault = 1'b0;
    logic empty_level_fault = 1'b0;
    logic cartridge_present = 1'b1;
    logic self_check_ok = 1'b1;
    int n_fail = 0;
    int check_count = 0;
    int run_len = 750;
    int run_cnt = 0;
    bit ok;
    always #2 clk = ~clk;
    plcd_decoder #(.TICK_CYCLES(TC), .DEB_CYCLES(2), .FILL_STROKES(2)) plcd_decoder_i (
        .clk(clk), .reset(reset), .cmd_line(cmd_line), .unit_two_fitted(unit_two_fitted),
        .motor_done(motor_done), .overload_fault(overload_fault),
        .supply_voltage_fault(supply_voltage_fault), .empty_level_fault(empty_level_fault),
        .cartridge_present(cartridge_present), .self_check_ok(self_check_ok),
        .status_out(status_out), .pump_unit_one(pump_unit_one),
        .pump_unit_two(pump_unit_two), .critical_fault(critical_fault));
    plcd_plc_model #(.TC(TC), .FILL_STROKES(2)) plcd_plc_model_i (
        .clk(clk), .status_out(status_out), .unit_two_fitted(unit_two_fitted),
        .cmd_line(cmd_line));
    // motor driver: one-cycle done pulse after run_len ticks of drive
    always @(negedge clk) begin
        motor_done <= (pump_unit_one || pump_unit_two) && run_cnt == run_len * TC;
        run_cnt <= (motor_done || !(pump_unit_one || pump_unit_two)) ? 0 : run_cnt + 1;
    end
    task automatic chk(input string what, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        check_count++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic pick(input int sel);
        return sel == 0 ? status_out : (sel == 1 ? pump_unit_one : pump_unit_two);
    endfunction
    task automatic wait_sig(input int sel, input logic v, input int max);
        for (int i = 0; i < max && pick(sel) !== v; i++) @(negedge clk);
        if (pick(sel) !== v) begin
            chk("awaited line", v, pick(sel));
            complete_run();
        end
    endtask
    task automatic pause();
        repeat (40) @(negedge clk);
    endtask
    // guarded send; a controller wait that runs out ends the run
    task automatic send_cmd(input int len);
        plcd_plc_model_i.send(len, 1'b1, ok);
        if (!ok) begin
            chk("controller wait", 1'b1, ok);
            complete_run();
        end
    endtask
    task automatic t_early();
        chk("status after reset", 1'b1, status_out);
        chk("critical after reset", 1'b0, critical_fault);
        plcd_plc_model_i.send(200, 0, ok);
        pause();
        chk("pump one early", 1'b0, pump_unit_one);
    endtask
    task automatic t_one();
        send_cmd(200);
        chk("ready seen", 1'b1, ok);
        wait_sig(1, 1'b1, 40);
        chk("status in run", 1'b0, status_out);
        wait_sig(1, 1'b0, 2000 * TC);
        chk("status after run", 1'b1, status_out);
        plcd_plc_model_i.send(200, 0, ok);
        pause();
        chk("pump one in hold-off", 1'b0, pump_unit_one);
    endtask
    task automatic t_two();
        unit_two_fitted = 1'b0;
        send_cmd(500);
        pause();
        chk("pump two unfitted", 1'b0, pump_unit_two);
        unit_two_fitted = 1'b1;
        send_cmd(600);
        pause();
        chk("pump two off window", 1'b0, pump_unit_two);
        send_cmd(1600);
        pause();
        chk("status long pulse", 1'b1, status_out);
        run_len = 1650;
        send_cmd(500);
        wait_sig(2, 1'b1, 40);
        chk("pump one idle", 1'b0, pump_unit_one);
        wait_sig(2, 1'b0, 2000 * TC);
        chk("slow run tolerated", 1'b0, critical_fault);
        chk("status slow run end", 1'b1, status_out);
        run_len = 750;
    endtask
    task automatic t_both();
        send_cmd(800);
        wait_sig(1, 1'b1, 40);
        wait_sig(2, 1'b1, 2000 * TC);
        chk("status between units", 1'b0, status_out);
        wait_sig(2, 1'b0, 2000 * TC);
        chk("status both end", 1'b1, status_out);
    endtask
    task automatic t_fill();
        int n1 = 0;
        int n2 = 0;
        int hi = 0;
        send_cmd(1200);
        for (int s = 0; s < 4; s++) begin
            wait_sig(0, 1'b0, 300);
            if (pump_unit_one === 1'b1) n1++;
            if (pump_unit_two === 1'b1) n2++;
            wait_sig(0, 1'b1, 2000 * TC);
            for (hi = 0; hi < 100 * TC && status_out === 1'b1; hi++) @(negedge clk);
            if (s < 3) chk_rng("fill gap cycles", 49 * TC, 51 * TC, hi);
        end
        chk_rng("unit one strokes", 2, 2, n1);
        chk_rng("unit two strokes", 2, 2, n2);
        repeat (400 * TC) @(negedge clk);
        chk("no extra stroke", 1'b1, status_out);
    endtask
    task automatic t_ack();
        send_cmd(200);
        wait_sig(1, 1'b1, 40);
        overload_fault = 1'b1;
        repeat (4) @(negedge clk);
        overload_fault = 1'b0;
        chk("status on fault", 1'b0, status_out);
        chk("pump stopped on fault", 1'b0, pump_unit_one);
        plcd_plc_model_i.send(200, 0, ok);
        pause();
        chk("stroke in error", 1'b0, pump_unit_one);
        self_check_ok = 1'b0;
        send_cmd(1400);
        chk("low seen before ack", 1'b1, ok);
        pause();
        chk("ack self-check fails", 1'b0, status_out);
        self_check_ok = 1'b1;
        send_cmd(1400);
        pause();
        chk("ack accepted", 1'b1, status_out);
    endtask
    task automatic t_empty();
        empty_level_fault = 1'b1;
        send_cmd(200);
        wait_sig(1, 1'b1, 40);
        wait_sig(1, 1'b0, 2000 * TC);
        repeat (50 * TC) @(negedge clk);
        chk("empty blink low", 1'b0, status_out);
        repeat (100 * TC) @(negedge clk);
        chk("empty blink high", 1'b1, status_out);
        cartridge_present = 1'b0;
        for (int i = 0; i < 3; i++) begin
            repeat (100 * TC) @(negedge clk);
            chk("cartridge out low", 1'b0, status_out);
        end
        empty_level_fault = 1'b0;
        cartridge_present = 1'b1;
        wait_sig(0, 1'b1, 40);
    endtask
    task automatic t_supply();
        supply_voltage_fault = 1'b1;
        repeat (4) @(negedge clk);
        supply_voltage_fault = 1'b0;
        chk("status on supply fault", 1'b0, status_out);
        send_cmd(1400);
        pause();
        chk("supply fault acked", 1'b1, status_out);
    endtask
    // short run: sticky critical fault, ack refused, cleared by a mid-run reset
    task automatic t_crit();
        run_len = 300;
        send_cmd(200);
        wait_sig(1, 1'b1, 40);
        wait_sig(1, 1'b0, 2000 * TC);
        chk("short run critical", 1'b1, critical_fault);
        chk("status on critical", 1'b0, status_out);
        send_cmd(1400);
        pause();
        chk("critical not acked", 1'b0, status_out);
        chk("critical kept", 1'b1, critical_fault);
        run_len = 750;
        reset = 1'b1;
        repeat (4) @(negedge clk);
        reset = 1'b0;
        chk("critical cleared by reset", 1'b0, critical_fault);
        chk("status after mid reset", 1'b1, status_out);
        chk("pump one after mid reset", 1'b0, pump_unit_one);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_early();
        t_one();
        t_two();
        t_both();
        t_fill();
        t_ack();
        t_empty();
        t_supply();
        t_crit();
        complete_run();
    end
endmodule
